// File: common/mux_port_pkg.sv
/*
 Shared constants and helpers for the serially set output multiplexer.
 Assumes a 50 MHz system clock and a two-wire bus master clocking the link.
*/
package mux_port_pkg;

    // Seven-bit slave addresses picked by the address-select pin
    localparam logic [6:0] SLAVE_ADDR_SEL1 = 7'h4e;
    localparam logic [6:0] SLAVE_ADDR_SEL0 = 7'h37;

    // Register indices on the serial port
    localparam logic [1:0] REG_STORED_A = 2'h0;
    localparam logic [1:0] REG_STORED_B = 2'h1;
    localparam logic [1:0] REG_SNAPSHOT = 2'h2;

    // Path-select codes carried in bits 7:6 of a stored register
    localparam logic [1:0] PATH_STORED_A = 2'h0;
    localparam logic [1:0] PATH_STORED_B = 2'h1;
    localparam logic [1:0] PATH_INPUT = 2'h2;
    localparam logic [1:0] PATH_RESET = PATH_INPUT;

    // Stored data field (byte bits 5:0) reset value
    localparam logic [5:0] STORED_RESET = 6'h00;
    // Upper field of the snapshot register always reads zero
    localparam logic [2:0] SNAPSHOT_PAD = 3'h0;

    // Index of the last bit of one byte on the link (eight bits, 7 down to 0)
    localparam logic [2:0] BIT_LAST = 3'h7;

    // Non-volatile programming time
    localparam int CLK_MHZ = 50;
    localparam int NV_PROG_MS = 10;
    localparam int NV_PROG_CYCLES = NV_PROG_MS * CLK_MHZ * 1000;
    localparam int BUSY_W = 20;

    // Output-port value of a stored data field: bit 5 then bits 3:0
    function automatic logic [4:0] portField(input logic [5:0] stored);
        portField = {stored[5], stored[3:0]};
    endfunction

    // Non-multiplexed bit of a stored data field
    function automatic logic nmoField(input logic [5:0] stored);
        nmoField = stored[4];
    endfunction

endpackage

// File: common/link_if.sv
/*
 Carrier between the system-clock control logic and the serial-clock link.
 Read values change at a start, at a stop, or when programming ends, which can fall mid-frame.
*/
`timescale 1ns/1ps
interface link_if;
    logic startHold;
    logic [6:0] ownAddr;
    logic [7:0] regA;
    logic [7:0] regB;
    logic [7:0] regP;
    logic [7:0] wrByte;
    logic wrToggle;
    logic sdaPullN;

    modport ctrl (
        output startHold,
        output ownAddr,
        output regA,
        output regB,
        output regP,
        input wrByte,
        input wrToggle,
        input sdaPullN
    );

    modport link (
        input startHold,
        input ownAddr,
        input regA,
        input regB,
        input regP,
        output wrByte,
        output wrToggle,
        output sdaPullN
    );
endinterface

// File: design/i2c_link_slave.sv
/*
 Two-wire slave shifter running on the bus clock itself.
 Assumes startHold is asserted by the control side from a start condition
 until the bus clock goes low, so each frame begins from a clean state.
*/
`timescale 1ns/1ps
module i2c_link_slave
    import mux_port_pkg::*;
(
    input wire logic scl,
    input wire logic rst,
    input wire logic sda,
    link_if.link lnk
);

    typedef enum logic [2:0] {
        ST_ADDR, ST_ACK_ADDR, ST_WRITE, ST_ACK_WRITE, ST_READ, ST_MASTER_ACK, ST_IDLE
    } link_state_t;

    link_state_t state_q, state_d;
    logic [2:0] cnt_q, cnt_d;
    logic [7:0] shift_q, shift_d;
    logic readMode_q, readMode_d;
    logic [1:0] idx_q, idx_d;
    logic [7:0] txByte_q, txByte_d;
    logic [7:0] wrByte_q, wrByte_d;
    logic wrToggle_q, wrToggle_d;
    logic pull_q, pull_d;
    logic linkRst;
    logic [7:0] full;

    // A start clears the link whatever state the last frame left it in
    assign linkRst = rst | lnk.startHold;
    assign lnk.wrByte = wrByte_q;
    assign lnk.wrToggle = wrToggle_q;
    assign lnk.sdaPullN = ~pull_q;

    function automatic logic [7:0] readReg(input logic [1:0] idx);
        case (idx)
            REG_STORED_A: readReg = lnk.regA;
            REG_STORED_B: readReg = lnk.regB;
            default: readReg = lnk.regP;
        endcase
    endfunction

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        shift_d = shift_q;
        readMode_d = readMode_q;
        idx_d = idx_q;
        txByte_d = txByte_q;
        wrByte_d = wrByte_q;
        wrToggle_d = wrToggle_q;
        full = {shift_q[6:0], sda};
        case (state_q)
            ST_ADDR: begin
                shift_d = full;
                cnt_d = cnt_q + 3'h1;
                if (cnt_q == BIT_LAST) begin
                    readMode_d = full[0];
                    // General call and foreign addresses get no answer
                    state_d = (full[7:1] == lnk.ownAddr) ? ST_ACK_ADDR : ST_IDLE;
                end
            end
            ST_ACK_ADDR: begin
                cnt_d = 3'h0;
                if (readMode_q) begin
                    idx_d = REG_STORED_A;
                    txByte_d = readReg(REG_STORED_A);
                    state_d = ST_READ;
                end else begin
                    state_d = ST_WRITE;
                end
            end
            ST_WRITE: begin
                shift_d = full;
                cnt_d = cnt_q + 3'h1;
                if (cnt_q == BIT_LAST) begin
                    wrByte_d = full;
                    wrToggle_d = ~wrToggle_q;
                    state_d = ST_ACK_WRITE;
                end
            end
            ST_ACK_WRITE: begin
                cnt_d = 3'h0;
                state_d = ST_WRITE;
            end
            ST_READ: begin
                cnt_d = cnt_q + 3'h1;
                if (cnt_q == BIT_LAST) begin
                    state_d = ST_MASTER_ACK;
                end
            end
            ST_MASTER_ACK: begin
                cnt_d = 3'h0;
                if (sda) begin
                    state_d = ST_IDLE;
                end else begin
                    idx_d = (idx_q == REG_SNAPSHOT) ? REG_STORED_A : idx_q + 2'h1;
                    txByte_d = readReg(idx_d);
                    state_d = ST_READ;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge scl or posedge linkRst) begin
        if (linkRst) begin
            state_q <= ST_ADDR;
            cnt_q <= 3'h0;
            shift_q <= 8'h00;
            readMode_q <= 1'b0;
            idx_q <= REG_STORED_A;
            txByte_q <= 8'h00;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            readMode_q <= readMode_d;
            idx_q <= idx_d;
            txByte_q <= txByte_d;
        end
    end

    // Written byte survives a start so the control side can still take it
    always_ff @(posedge scl or posedge rst) begin
        if (rst) begin
            wrByte_q <= 8'h00;
            wrToggle_q <= 1'b0;
        end else begin
            wrByte_q <= wrByte_d;
            wrToggle_q <= wrToggle_d;
        end
    end

    // Data line changes only while the clock is low
    always_comb begin
        case (state_q)
            ST_ACK_ADDR, ST_ACK_WRITE: pull_d = 1'b1;
            ST_READ: pull_d = ~txByte_q[BIT_LAST - cnt_q];
            default: pull_d = 1'b0;
        endcase
    end

    always_ff @(negedge scl or posedge linkRst) begin
        if (linkRst) begin
            pull_q <= 1'b0;
        end else begin
            pull_q <= pull_d;
        end
    end

endmodule

// File: design/serial_set_output_mux.sv
/*
 Output-port multiplexer with two stored registers set over a two-wire bus.
 Assumes scl is the bus clock from an external master and sdaIn/sdaOut/sdaOeN
 are resolved into one open-drain wire outside; all other pins are asynchronous.
*/
`timescale 1ns/1ps
// What this block does
// - After reset the output port follows the input port.
// - Override pin low forces every output, both kinds, to zero.
// - Write-protect high blocks programming of the stored data bits; the path bits still change.
// - Mux-select low drives stored data per the path bits.
// - Mux-select high drives the output port from the input port.
// - Non-multiplexed latch transparent at mux-select low on a stored path with override high, holding otherwise.
// - Path changes by writing bits 7:6; output port always driven.
// - Path bits reset to 10, the input-port path.
// - A newly written path takes effect only at a stop condition.
// - Stored registers A and B at indices 0 and 1, read and write.
// - Read-only register at index 2 holds the five input bits.
// - Slave-only link at either standard or fast bus rate.
// - Address-select pin picks one of two seven-bit slave addresses.
// - Select 1 answers 1001110, select 0 answers 0110111, no general call.
// - Path 00 stored A, 01 stored B, 10 input port; 11 unused.
// - Reads return A, then B, then the snapshot, then A again, until the master withholds its acknowledge.
// - Input port is captured into the snapshot at each start.
module serial_set_output_mux
    import mux_port_pkg::*;
#(
    parameter int PROG_CYCLES = NV_PROG_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOeN,
    input wire logic [4:0] iPort,
    input wire logic forceZeroLevelN,
    input wire logic writeProtect,
    input wire logic muxSelect,
    input wire logic slaveIdSelect,
    output logic [4:0] yPort,
    output logic nonMuxOut
);

    typedef struct packed {
        logic [4:0] iPort;
        logic forceZeroN;
        logic wp;
        logic muxSel;
        logic idSel;
        logic scl;
        logic sda;
        logic wrToggle;
    } pins_t;

    // Toggle resets to the link's own level, so no false byte follows reset
    localparam pins_t PINS_IDLE = '{5'h1f, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};

    link_if lnk ();

    i2c_link_slave link (
        .scl(scl),
        .rst(rst),
        .sda(sdaIn),
        .lnk(lnk.link)
    );

    // Synchronisers: first stage feeds only the second
    pins_t meta_q, meta_d;
    pins_t pin_q;
    logic lastScl_q, lastSda_q, lastToggle_q;

    always_comb begin
        meta_d.iPort = iPort;
        meta_d.forceZeroN = forceZeroLevelN;
        meta_d.wp = writeProtect;
        meta_d.muxSel = muxSelect;
        meta_d.idSel = slaveIdSelect;
        meta_d.scl = scl;
        meta_d.sda = sdaIn;
        meta_d.wrToggle = lnk.wrToggle;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= PINS_IDLE;
            pin_q <= PINS_IDLE;
            lastScl_q <= 1'b1;
            lastSda_q <= 1'b1;
            lastToggle_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            pin_q <= meta_q;
            lastScl_q <= pin_q.scl;
            lastSda_q <= pin_q.sda;
            lastToggle_q <= pin_q.wrToggle;
        end
    end

    // Bus conditions seen on the system clock
    logic startEvt, stopEvt, wrEvt;

    always_comb begin
        startEvt = pin_q.scl & lastScl_q & lastSda_q & ~pin_q.sda;
        stopEvt = pin_q.scl & lastScl_q & ~lastSda_q & pin_q.sda;
        wrEvt = pin_q.wrToggle ^ lastToggle_q;
    end

    // Frame and write-capture state
    logic startHold_q, startHold_d;
    logic [4:0] snapshot_q, snapshot_d;
    logic [7:0] pendByte_q, pendByte_d;
    logic pendValid_q, pendValid_d;
    logic [6:0] ownAddr_q, ownAddr_d;

    always_comb begin
        startHold_d = startHold_q;
        snapshot_d = snapshot_q;
        pendByte_d = pendByte_q;
        pendValid_d = pendValid_q;
        ownAddr_d = ownAddr_q;
        // Hold the link in reset from start until the clock falls
        if (startEvt) begin
            startHold_d = 1'b1;
            snapshot_d = pin_q.iPort;
        end else if (!pin_q.scl) begin
            startHold_d = 1'b0;
        end
        // Address only follows the pin between frames
        if (startEvt) begin
            ownAddr_d = pin_q.idSel ? SLAVE_ADDR_SEL1 : SLAVE_ADDR_SEL0;
        end
        // A new byte wins over the stop that would clear the flag
        if (wrEvt) begin
            pendByte_d = lnk.wrByte;
            pendValid_d = 1'b1;
        end else if (stopEvt) begin
            pendValid_d = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            startHold_q <= 1'b0;
            snapshot_q <= 5'h00;
            pendByte_q <= 8'h00;
            pendValid_q <= 1'b0;
            ownAddr_q <= SLAVE_ADDR_SEL1;
        end else begin
            startHold_q <= startHold_d;
            snapshot_q <= snapshot_d;
            pendByte_q <= pendByte_d;
            pendValid_q <= pendValid_d;
            ownAddr_q <= ownAddr_d;
        end
    end

    // Commit at stop and non-volatile programming
    logic [1:0] pathSel_q, pathSel_d;
    logic [5:0] storedA_q, storedA_d;
    logic [5:0] storedB_q, storedB_d;
    logic [7:0] progByte_q, progByte_d;
    logic busy_q, busy_d;
    logic [BUSY_W-1:0] busyCnt_q, busyCnt_d;
    logic progTarget;

    always_comb begin
        pathSel_d = pathSel_q;
        storedA_d = storedA_q;
        storedB_d = storedB_q;
        progByte_d = progByte_q;
        busy_d = busy_q;
        busyCnt_d = busyCnt_q;
        progTarget = (pendByte_q[7:6] == PATH_STORED_A) || (pendByte_q[7:6] == PATH_STORED_B);
        if (stopEvt && pendValid_q) begin
            pathSel_d = pendByte_q[7:6];
            // A byte arriving mid-programming sets the path but is not programmed
            if (progTarget && !pin_q.wp && !busy_q) begin
                progByte_d = pendByte_q;
                busy_d = 1'b1;
                busyCnt_d = '0;
            end
        end
        if (busy_q) begin
            if (busyCnt_q == BUSY_W'(PROG_CYCLES - 1)) begin
                busy_d = 1'b0;
                if (progByte_q[7:6] == PATH_STORED_A) begin
                    storedA_d = progByte_q[5:0];
                end else begin
                    storedB_d = progByte_q[5:0];
                end
            end else begin
                busyCnt_d = busyCnt_q + BUSY_W'(1);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pathSel_q <= PATH_RESET;
            storedA_q <= STORED_RESET;
            storedB_q <= STORED_RESET;
            progByte_q <= 8'h00;
            busy_q <= 1'b0;
            busyCnt_q <= '0;
        end else begin
            pathSel_q <= pathSel_d;
            storedA_q <= storedA_d;
            storedB_q <= storedB_d;
            progByte_q <= progByte_d;
            busy_q <= busy_d;
            busyCnt_q <= busyCnt_d;
        end
    end

    // Path bits are shared, so both stored registers read them back
    assign lnk.startHold = startHold_q;
    assign lnk.ownAddr = ownAddr_q;
    assign lnk.regA = {pathSel_q, storedA_q};
    assign lnk.regB = {pathSel_q, storedB_q};
    assign lnk.regP = {SNAPSHOT_PAD, snapshot_q};

    // Output multiplexer
    logic [4:0] yPort_q, yPort_d;
    logic nonMux_q, nonMux_d;
    logic nmoLatch_q, nmoLatch_d;
    logic sdaOeN_q;
    logic useStored;
    logic [5:0] selStored;

    always_comb begin
        case (pathSel_q)
            PATH_STORED_A: begin
                useStored = 1'b1;
                selStored = storedA_q;
            end
            PATH_STORED_B: begin
                useStored = 1'b1;
                selStored = storedB_q;
            end
            // Unused code 11 falls back to the input port
            default: begin
                useStored = 1'b0;
                selStored = STORED_RESET;
            end
        endcase
        nmoLatch_d = nmoLatch_q;
        // Port is always driven from some source
        yPort_d = pin_q.iPort;
        if (!pin_q.forceZeroN) begin
            yPort_d = 5'h00;
        end else if (pin_q.muxSel) begin
            yPort_d = pin_q.iPort;
        end else if (useStored) begin
            yPort_d = portField(selStored);
            nmoLatch_d = nmoField(selStored);
        end else begin
            yPort_d = pin_q.iPort;
        end
        nonMux_d = pin_q.forceZeroN ? nmoLatch_d : 1'b0;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            yPort_q <= 5'h00;
            nonMux_q <= 1'b0;
            nmoLatch_q <= 1'b0;
        end else begin
            yPort_q <= yPort_d;
            nonMux_q <= nonMux_d;
            nmoLatch_q <= nmoLatch_d;
        end
    end

    // Open-drain data line only ever pulls low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sdaOeN_q <= 1'b1;
        end else begin
            sdaOeN_q <= 1'b1;
        end
    end

    assign yPort = yPort_q;
    assign nonMuxOut = nonMux_q;
    assign sdaOut = ~sdaOeN_q;
    assign sdaOeN = lnk.sdaPullN;

endmodule

// File: sim/serial_set_output_mux_properties.sv
/*
 Concurrent checks on the pins of the serially set output multiplexer.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
module serial_set_output_mux_properties
    import mux_port_pkg::*;
#(
    parameter int PROG_CYCLES = NV_PROG_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic scl,
    input wire logic sdaOut,
    input wire logic sdaOeN,
    input wire logic [4:0] iPort,
    input wire logic forceZeroLevelN,
    input wire logic muxSelect,
    input wire logic [4:0] yPort,
    input wire logic nonMuxOut
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Long enough for the two-flop synchronisers plus the output flop
    sequence forcedLow;
        !forceZeroLevelN [*4];
    endsequence
    sequence inputPath;
        (muxSelect && forceZeroLevelN && $stable(iPort)) [*5];
    endsequence
    sequence busIdle;
        scl [*8];
    endsequence

    a_force_zero: assert property (forcedLow |-> yPort == 5'h00 && !nonMuxOut)
        else $error("outputs not forced to zero");
    a_input_path: assert property (inputPath |-> yPort == iPort)
        else $error("output port does not follow input port");
    a_latch_hold: assert property ((muxSelect && forceZeroLevelN) [*6] |-> $stable(nonMuxOut))
        else $error("non-multiplexed output moved while latched");
    a_ack_on_low: assert property ($changed(sdaOeN) |-> !scl)
        else $error("data line changed with bus clock high");
    a_hold_scl_high: assert property (scl && $past(scl) |-> $stable(sdaOeN))
        else $error("data line not steady during clock high");
    a_idle_release: assert property (busIdle |-> sdaOeN)
        else $error("data line held while bus idle");
    a_drive_low_only: assert property (!sdaOeN |-> !sdaOut)
        else $error("data line driven high");
    a_ack_bounded: assert property ($fell(sdaOeN) |-> ##[1:80] sdaOeN)
        else $error("data line held low too long");
endmodule

bind serial_set_output_mux serial_set_output_mux_properties #(.PROG_CYCLES(PROG_CYCLES)) chk (
    .clk(clk), .rst(rst), .scl(scl), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .iPort(iPort),
    .forceZeroLevelN(forceZeroLevelN), .muxSelect(muxSelect), .yPort(yPort),
    .nonMuxOut(nonMuxOut)
);

// File: sim/bus_master_model.sv
/*
 Behavioural two-wire bus master, one bit each 160 ns.
 Assumes a pull-up outside resolves sda from this model and the slave.
*/
`timescale 1ns/1ps
module bus_master_model (
    output logic scl,
    output logic sdaDrvN,
    input wire logic sda
);
    // Clock stands high outside frames
    initial begin
        scl = 1'b1;
        sdaDrvN = 1'b1;
    end

    // Low 100 ns keeps clear of the slave start-hold release
    task automatic bitSlot(input logic drvN, output logic seen);
        scl = 1'b0;
        #20 sdaDrvN = drvN;
        #80 scl = 1'b1;
        #30 seen = sda;
        #30;
    endtask

    // Odd offset keeps frames out of phase with the system clock
    task automatic sendStart();
        #87 sdaDrvN = 1'b0;
        #80;
    endtask

    // Ends the ninth clock so the slave lets go of its acknowledge
    task automatic parkLow();
        scl = 1'b0;
        #20;
    endtask

    task automatic sendStop();
        logic s;
        bitSlot(1'b0, s);
        #20 sdaDrvN = 1'b1;
        #80;
    endtask

    task automatic sendByte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitSlot(b[i], s);
        end
        bitSlot(1'b1, s);
        ack = !s;
    endtask

    task automatic getByte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitSlot(1'b1, s);
            b[i] = s;
        end
        bitSlot(last, s);
    endtask
endmodule

// File: sim/test_serial_set_output_mux.sv
/*
 Self-checking bench for the serially set output multiplexer.
 Assumes the bus master model and the bound checker are compiled with it.
*/
`timescale 1ns/1ps
module test_serial_set_output_mux;
    import mux_port_pkg::*;
    localparam int PROG = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] iPort = 5'h15;
    logic forceZeroLevelN = 1'b1;
    logic writeProtect = 1'b0;
    logic muxSelect = 1'b0;
    logic slaveIdSelect = 1'b1;
    logic scl, sdaDrvN, sdaOut, sdaOeN, nonMuxOut, ok, sdaWire;
    logic [4:0] yPort;
    int nMismatch = 0;
    int cmpCount = 0;
    int cycles = 0;
    logic [6:0] addrTab [4] = '{SLAVE_ADDR_SEL1, 7'h00, SLAVE_ADDR_SEL0, SLAVE_ADDR_SEL1};

    always #10 clk = ~clk;
    assign sdaWire = sdaDrvN & (sdaOeN | sdaOut);

    serial_set_output_mux #(.PROG_CYCLES(PROG)) DUT (
        .clk(clk), .rst(rst), .scl(scl), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
        .iPort(iPort), .forceZeroLevelN(forceZeroLevelN), .writeProtect(writeProtect),
        .muxSelect(muxSelect), .slaveIdSelect(slaveIdSelect), .yPort(yPort),
        .nonMuxOut(nonMuxOut)
    );
    bus_master_model m (.scl(scl), .sdaDrvN(sdaDrvN), .sda(sdaWire));

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            nMismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("compares %0d mismatches %0d", cmpCount, nMismatch);
        if (nMismatch == 0 && cmpCount > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic waitClk(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic pins(input logic [4:0] ip, input logic fz, input logic wp, input logic ms);
        @(posedge clk);
        iPort <= ip;
        forceZeroLevelN <= fz;
        writeProtect <= wp;
        muxSelect <= ms;
        waitClk(6);
    endtask

    // Leaves the frame open so the caller decides when the stop comes
    task automatic regWrite(input logic [7:0] val);
        logic a1, a2;
        m.sendStart();
        m.sendByte({SLAVE_ADDR_SEL1, 1'b0}, a1);
        m.sendByte(val, a2);
        m.parkLow();
        check("write ack", {6'h00, a1, a2}, 8'h03);
    endtask

    task automatic readAll(input logic [31:0] exp);
        logic a;
        logic [7:0] b;
        m.sendStart();
        m.sendByte({SLAVE_ADDR_SEL1, 1'b1}, a);
        check("read ack", {7'h00, a}, 8'h01);
        for (int i = 0; i < 4; i++) begin
            m.getByte(i == 3, b);
            check("read byte", b, exp[31 - 8 * i -: 8]);
        end
        m.sendStop();
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            nMismatch++;
            conclude();
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        check("reset outputs", {sdaOut, sdaOeN, nonMuxOut, yPort}, 8'h40);
        rst <= 1'b0;
        waitClk(6);
        check("yPort", yPort, 5'h15);
        readAll({8'h80, 8'h80, 8'h15, 8'h80});
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            slaveIdSelect <= (k < 2);
            waitClk(4);
            m.sendStart();
            m.sendByte({addrTab[k], 1'b0}, ok);
            m.sendStop();
            check("address ack", {7'h00, ok}, {7'h00, k[0] == 1'b0});
        end
        @(posedge clk);
        slaveIdSelect <= 1'b1;
        waitClk(4);
        regWrite(8'h3a);
        waitClk(10);
        check("yPort", yPort, 5'h15);
        m.sendStop();
        waitClk(8);
        check("yPort", yPort, 5'h00);
        waitClk(PROG + 10);
        check("outputs", {nonMuxOut, yPort}, 6'h3a);
        pins(5'h0a, 1'b1, 1'b0, 1'b1);
        check("outputs", {nonMuxOut, yPort}, 6'h2a);
        regWrite(8'h45);
        m.sendStop();
        waitClk(PROG + 20);
        check("outputs", {nonMuxOut, yPort}, 6'h2a);
        pins(5'h0a, 1'b1, 1'b0, 1'b0);
        check("outputs", {nonMuxOut, yPort}, 6'h05);
        pins(5'h0a, 1'b1, 1'b1, 1'b0);
        regWrite(8'h11);
        m.sendStop();
        waitClk(PROG + 20);
        check("outputs", {nonMuxOut, yPort}, 6'h3a);
        readAll({8'h3a, 8'h05, 8'h0a, 8'h3a});
        pins(5'h0a, 1'b1, 1'b0, 1'b0);
        regWrite(8'h80);
        m.sendStop();
        waitClk(8);
        check("outputs", {nonMuxOut, yPort}, 6'h2a);
        pins(5'h0a, 1'b0, 1'b0, 1'b0);
        check("outputs", {nonMuxOut, yPort}, 6'h00);
        conclude();
    end
endmodule
